// ===== design/ldcsr_pkg.sv
package ldcsr_pkg;
  localparam logic [7:0] ADDR_GLOBAL_CONTROL = 8'h01;
  localparam logic [7:0] ADDR_REFRESH_LOW = 8'h02;
  localparam logic [7:0] ADDR_REFRESH_HIGH = 8'h03;
  localparam logic [7:0] ADDR_CH_EN_UPPER = 8'h04;
  localparam logic [7:0] ADDR_CH_EN_LOWER = 8'h05;
  localparam logic [7:0] ADDR_OPEN_UPPER = 8'h06;
  localparam logic [7:0] ADDR_OPEN_LOWER = 8'h07;
  localparam logic [7:0] ADDR_SHORT_UPPER = 8'h08;
  localparam logic [7:0] ADDR_SHORT_LOWER = 8'h09;

  localparam int CTL_FAULT_PIN_BIT = 7;
  localparam int CTL_LATCH_BIT = 6;
  localparam int CTL_STH_LSB = 4;
  localparam int CTL_RAMP_LSB = 2;
  localparam int CTL_STAGGER_BIT = 1;
  localparam int CTL_CHIP_EN_BIT = 0;
  localparam int OT_FLAG_BIT = 2;

  localparam logic [7:0] CTL_RESET = 8'h40;
  localparam logic [1:0] DIV_LOW_RESET = 2'h1;
  localparam logic [7:0] DIV_HIGH_RESET = 8'h6a;
  localparam logic [9:0] DIV_RESET = {DIV_HIGH_RESET, DIV_LOW_RESET};
  localparam logic [9:0] DIV_OFF = 10'h000;
  localparam logic [15:0] CH_EN_RESET = 16'hffff;

  localparam int CLK_HZ = 10_000_000;
  localparam int CYC_PER_US = CLK_HZ / 1_000_000;
  localparam int OPEN_QUAL_US = 4000;
  localparam int HICCUP_PERIOD_US = 1000;
  localparam int RETRY_US = 32;
  localparam int STAGGER_US = 40;
  localparam int OPEN_QUAL_CYCLES = OPEN_QUAL_US * CYC_PER_US;
  localparam int HICCUP_PERIOD_CYCLES = HICCUP_PERIOD_US * CYC_PER_US;
  localparam int RETRY_CYCLES = RETRY_US * CYC_PER_US;
  localparam int STAGGER_CYCLES = STAGGER_US * CYC_PER_US;

  // refresh counter ticks at twice 127500 Hz, scaled by dimming_freq_sel / 250
  localparam longint REFRESH_BASE_HZ = 127500;
  localparam longint DIMMING_FREQ_SEL_REF_HZ = 250;
  localparam longint DIMMING_FREQ_SEL_220_HZ = 220;
  localparam longint DIMMING_FREQ_SEL_250_HZ = 250;
  localparam longint DIMMING_FREQ_SEL_280_HZ = 280;
  localparam longint DIMMING_FREQ_SEL_330_HZ = 330;
  localparam logic [5:0] TICK_220 = 6'((longint'(CLK_HZ) * DIMMING_FREQ_SEL_REF_HZ)
    / (2 * REFRESH_BASE_HZ * DIMMING_FREQ_SEL_220_HZ));
  localparam logic [5:0] TICK_250 = 6'((longint'(CLK_HZ) * DIMMING_FREQ_SEL_REF_HZ)
    / (2 * REFRESH_BASE_HZ * DIMMING_FREQ_SEL_250_HZ));
  localparam logic [5:0] TICK_280 = 6'((longint'(CLK_HZ) * DIMMING_FREQ_SEL_REF_HZ)
    / (2 * REFRESH_BASE_HZ * DIMMING_FREQ_SEL_280_HZ));
  localparam logic [5:0] TICK_330 = 6'((longint'(CLK_HZ) * DIMMING_FREQ_SEL_REF_HZ)
    / (2 * REFRESH_BASE_HZ * DIMMING_FREQ_SEL_330_HZ));

  typedef enum logic [2:0] {
    FT_WATCH = 3'h1,
    FT_OFF = 3'h2,
    FT_RETRY = 3'h4
  } ldcsr_fault_state_t;
endpackage

// ===== design/ldcsr_fault_timer.sv
`timescale 1ns/1ps
module ldcsr_fault_timer
  import ldcsr_pkg::*;
#(
  parameter int QUAL_CYCLES = OPEN_QUAL_CYCLES,
  parameter int PERIOD_CYCLES = HICCUP_PERIOD_CYCLES,
  parameter int TRY_CYCLES = RETRY_CYCLES
) (
  input wire logic clock_in,
  input wire logic rst_in,
  input wire logic open_in,
  input wire logic short_in,
  input wire logic conducting_in,
  input wire logic latch_mode_in,
  input wire logic chip_en_in,
  output logic open_trip_out,
  output logic short_trip_out,
  output logic faulted_out,
  output logic retry_out
);
  localparam int CW = $clog2(QUAL_CYCLES + PERIOD_CYCLES + 1);
  ldcsr_fault_state_t state;
  logic [CW-1:0] cnt;
  logic cond;

  assign cond = open_in | short_in;
  assign faulted_out = (state != FT_WATCH);
  assign retry_out = (state == FT_RETRY);

  always_ff @(posedge clock_in) begin
    open_trip_out <= 1'b0;
    short_trip_out <= 1'b0;
    if (rst_in) begin
      state <= FT_WATCH;
      cnt <= '0;
    end else begin
      case (state)
        FT_WATCH: begin
          // RULE19 qualify fault time
          if (conducting_in && cond) begin
            if (cnt == CW'(QUAL_CYCLES - 1)) begin
              state <= FT_OFF;
              cnt <= '0;
              open_trip_out <= open_in;
              short_trip_out <= short_in;
            end else begin
              cnt <= cnt + 1'b1;
            end
          end else begin
            cnt <= '0;
          end
        end
        FT_OFF: begin
          // RULE18 latched off until disable
          if (!chip_en_in) begin
            state <= FT_WATCH;
            cnt <= '0;
          end else if (!latch_mode_in) begin
            // RULE17 retry each period
            if (cnt == CW'(PERIOD_CYCLES - 1)) begin
              state <= FT_RETRY;
              cnt <= '0;
            end else begin
              cnt <= cnt + 1'b1;
            end
          end
        end
        FT_RETRY: begin
          if (!chip_en_in) begin
            state <= FT_WATCH;
            cnt <= '0;
          end else if (cnt == CW'(TRY_CYCLES - 1)) begin
            state <= cond ? FT_OFF : FT_WATCH;
            cnt <= '0;
          end else begin
            cnt <= cnt + 1'b1;
          end
        end
        default: begin
          state <= FT_WATCH;
          cnt <= '0;
        end
      endcase
    end
  end

  a_latch_holds_off: assert property ( // RULE18
    @(posedge clock_in) disable iff (rst_in)
    (state == FT_OFF && latch_mode_in && chip_en_in) |=> state == FT_OFF
  ) else $error("latch-off channel left the off state");

  a_retry_window: assert property ( // RULE17
    @(posedge clock_in) disable iff (rst_in)
    ($rose(retry_out) && chip_en_in) |-> retry_out [*8]
  ) else $error("hiccup retry window ended too early");
endmodule

// ===== design/ldcsr_regs.sv
`timescale 1ns/1ps
// Function
// RULE1 - control bit 7 picks refresh output or active-low fault pin
// RULE2 - control bit 6, reset 1, picks latch-off; 0 gives hiccup retry
// RULE3 - bits 5:4 pick short threshold 2V, 3V, 4V or 5V
// RULE4 - bits 3:2 pick current ramp: none, 5, 10 or 20 us
// RULE5 - stagger bit makes each channel start 40 us after previous one
// RULE6 - control bit 0 is chip enable; channels run only while set
// RULE7 - register refresh_low_and_overtemp bit 2 is sticky read-only over-temperature flag
// RULE8 - divisor low bits in refresh_low_and_overtemp (reset 01), high bits refresh_divisor_high (6A)
// RULE9 - divisor zero holds the refresh pin constantly high
// RULE10 - nonzero divisor gives 127500/divisor Hz, scaled by dimming_freq_sel/250
// RULE11 - low divisor bits wait; writing high byte commits all ten
// RULE12 - reset divisor and dimming rate give 300 Hz refresh
// RULE13 - channel enables in channel_enable_upper and channel_enable_lower, reset to one
// RULE14 - open-load flags in open_fault_upper and open_fault_lower, highest channel first
// RULE15 - short flags in short_fault_upper and short_fault_lower, highest channel first
// RULE16 - reading a flag clears it; fault pin then released (hiccup mode: pin stays low while any channel is faulted, whatever is read)
// RULE17 - hiccup mode retries a faulted channel 32 us every 1 ms
// RULE18 - latch-off keeps faulted channel off until chip disabled
// RULE19 - open or short must persist 4 ms before tripping
// RULE20 - refresh counter reloads from committed divisor, toggles at end
module ldcsr_regs
  import ldcsr_pkg::*;
#(
  parameter int CHANNELS = 16,
  parameter int QUAL_CYCLES = OPEN_QUAL_CYCLES,
  parameter int PERIOD_CYCLES = HICCUP_PERIOD_CYCLES
) (
  input wire logic clock_in,
  input wire logic rst_in,
  input wire logic [7:0] reg_addr_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  input wire logic [7:0] reg_wdata_in,
  output logic [7:0] reg_rdata_out,
  input wire logic [1:0] dimming_freq_sel_in,
  input wire logic dim_period_start_in,
  input wire logic [CHANNELS-1:0] open_detect_in,
  input wire logic [CHANNELS-1:0] short_detect_in,
  input wire logic overtemp_in,
  output logic [CHANNELS-1:0] channel_on_out,
  output logic [CHANNELS-1:0] channel_start_out,
  output logic [1:0] short_threshold_sel_out,
  output logic [1:0] ramp_rate_sel_out,
  output logic refresh_fault_pin_out,
  output logic refresh_fault_pin_oe_out
);
  localparam int SW = 2 * CHANNELS + 1;
  localparam int STAG_GAP = STAGGER_CYCLES;
  localparam int SCW = $clog2(STAGGER_CYCLES + 1);
  logic [7:0] ctrl;
  logic [1:0] div_low_pending;
  logic [9:0] refresh_divisor;
  logic [CHANNELS-1:0] channel_enable_bits;
  logic [CHANNELS-1:0] open_load_flags;
  logic [CHANNELS-1:0] shorted_led_flags;
  logic overtemp_flag;
  logic [SW-1:0] sync1, sync2, sync3, det;
  logic [CHANNELS-1:0] open_det, short_det, open_set, short_set;
  logic [CHANNELS-1:0] open_clr, short_clr, faulted, retry;
  logic otp_active;
  logic fault_pin_select, latch_mode, phase_stagger_enable, chip_en;
  logic wr_ctrl, wr_low, wr_high, rd_hit;
  logic [5:0] pre_cnt, tick_max;
  logic tick;
  logic [9:0] refresh_cnt;
  logic refresh_level;
  logic fault_low;
  logic next_pin_out, next_pin_oe;
  logic [CHANNELS-1:0] next_channel_on;
  logic stag_active;
  logic [3:0] stag_idx;
  logic [SCW-1:0] stag_cnt;
  logic [7:0] next_rdata;
  assign fault_pin_select = ctrl[CTL_FAULT_PIN_BIT];
  assign latch_mode = ctrl[CTL_LATCH_BIT];
  assign phase_stagger_enable = ctrl[CTL_STAGGER_BIT];
  assign chip_en = ctrl[CTL_CHIP_EN_BIT];
  // RULE3 threshold select out
  assign short_threshold_sel_out = ctrl[CTL_STH_LSB +: 2];
  // RULE4 ramp select out
  assign ramp_rate_sel_out = ctrl[CTL_RAMP_LSB +: 2];

  assign wr_ctrl = reg_wr_in && (reg_addr_in == ADDR_GLOBAL_CONTROL);
  assign wr_low = reg_wr_in && (reg_addr_in == ADDR_REFRESH_LOW);
  assign wr_high = reg_wr_in && (reg_addr_in == ADDR_REFRESH_HIGH);
  // pin inputs: three stages, change taken when stages 2 and 3 agree
  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      sync1 <= '0;
      sync2 <= '0;
      sync3 <= '0;
      det <= '0;
    end else begin
      sync1 <= {overtemp_in, short_detect_in, open_detect_in};
      sync2 <= sync1;
      sync3 <= sync2;
      det <= (sync2 & sync3) | (det & (sync2 ^ sync3));
    end
  end
  assign open_det = det[CHANNELS-1:0];
  assign short_det = det[2*CHANNELS-1:CHANNELS];
  assign otp_active = det[SW-1];
  // control register
  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      ctrl <= CTL_RESET;
    end else if (wr_ctrl) begin
      // RULE1 RULE2 RULE6 control writes
      ctrl <= reg_wdata_in;
    end
  end
  // divisor with pending low bits
  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      // RULE8 RULE12 divisor reset
      div_low_pending <= DIV_LOW_RESET;
      refresh_divisor <= DIV_RESET;
    end else begin
      // RULE11 low bits wait for high byte
      if (wr_low) begin
        div_low_pending <= reg_wdata_in[1:0];
      end
      if (wr_high) begin
        refresh_divisor <= {reg_wdata_in, div_low_pending};
      end
    end
  end
  // channel enables
  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      channel_enable_bits <= CH_EN_RESET;
    end else if (reg_wr_in) begin
      // RULE13 enable bytes
      if (reg_addr_in == ADDR_CH_EN_UPPER) begin
        channel_enable_bits[15:8] <= reg_wdata_in;
      end else if (reg_addr_in == ADDR_CH_EN_LOWER) begin
        channel_enable_bits[7:0] <= reg_wdata_in;
      end
    end
  end
  // per-channel fault timers
  genvar gi;
  generate
    for (gi = 0; gi < CHANNELS; gi++) begin : g_ch
      ldcsr_fault_timer #(
        .QUAL_CYCLES(QUAL_CYCLES),
        .PERIOD_CYCLES(PERIOD_CYCLES),
        .TRY_CYCLES(RETRY_CYCLES)
      ) u_timer (
        .clock_in(clock_in),
        .rst_in(rst_in),
        .open_in(open_det[gi]),
        .short_in(short_det[gi]),
        .conducting_in(chip_en && channel_enable_bits[gi] && !otp_active),
        .latch_mode_in(latch_mode),
        .chip_en_in(chip_en),
        .open_trip_out(open_set[gi]),
        .short_trip_out(short_set[gi]),
        .faulted_out(faulted[gi]),
        .retry_out(retry[gi])
      );
      // RULE6 RULE17 RULE18 channel gating
      assign next_channel_on[gi] = chip_en && channel_enable_bits[gi]
        && !otp_active && (!faulted[gi] || retry[gi]);
    end
  endgenerate
  // clear-on-read of the flag byte actually returned
  always_comb begin
    open_clr = '0;
    short_clr = '0;
    if (reg_rd_in) begin
      if (reg_addr_in == ADDR_OPEN_UPPER) begin
        open_clr[15:8] = open_load_flags[15:8];
      end else if (reg_addr_in == ADDR_OPEN_LOWER) begin
        open_clr[7:0] = open_load_flags[7:0];
      end else if (reg_addr_in == ADDR_SHORT_UPPER) begin
        short_clr[15:8] = shorted_led_flags[15:8];
      end else if (reg_addr_in == ADDR_SHORT_LOWER) begin
        short_clr[7:0] = shorted_led_flags[7:0];
      end
    end
  end
  // fault flags, set wins over clear
  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      open_load_flags <= '0;
      shorted_led_flags <= '0;
      overtemp_flag <= 1'b0;
    end else begin
      // RULE14 RULE15 RULE16 sticky flags
      open_load_flags <= (open_load_flags & ~open_clr) | open_set;
      shorted_led_flags <= (shorted_led_flags & ~short_clr) | short_set;
      // RULE7 sticky overtemp
      overtemp_flag <= overtemp_flag | otp_active;
    end
  end
  // register read
  always_comb begin
    next_rdata = 8'h00;
    rd_hit = reg_rd_in;
    if (reg_addr_in == ADDR_GLOBAL_CONTROL) begin
      next_rdata = ctrl;
    end else if (reg_addr_in == ADDR_REFRESH_LOW) begin
      next_rdata[OT_FLAG_BIT] = overtemp_flag;
      next_rdata[1:0] = div_low_pending;
    end else if (reg_addr_in == ADDR_REFRESH_HIGH) begin
      next_rdata = refresh_divisor[9:2];
    end else if (reg_addr_in == ADDR_CH_EN_UPPER) begin
      next_rdata = channel_enable_bits[15:8];
    end else if (reg_addr_in == ADDR_CH_EN_LOWER) begin
      next_rdata = channel_enable_bits[7:0];
    end else if (reg_addr_in == ADDR_OPEN_UPPER) begin
      next_rdata = open_load_flags[15:8];
    end else if (reg_addr_in == ADDR_OPEN_LOWER) begin
      next_rdata = open_load_flags[7:0];
    end else if (reg_addr_in == ADDR_SHORT_UPPER) begin
      next_rdata = shorted_led_flags[15:8];
    end else if (reg_addr_in == ADDR_SHORT_LOWER) begin
      next_rdata = shorted_led_flags[7:0];
    end
  end

  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      reg_rdata_out <= 8'h00;
    end else if (rd_hit) begin
      reg_rdata_out <= next_rdata;
    end
  end

  // refresh tick prescaler, rate follows dimming frequency
  always_comb begin
    case (dimming_freq_sel_in)
      2'h0: tick_max = TICK_220 - 6'h01;
      2'h1: tick_max = TICK_250 - 6'h01;
      2'h2: tick_max = TICK_280 - 6'h01;
      default: tick_max = TICK_330 - 6'h01;
    endcase
  end
  assign tick = (pre_cnt >= tick_max);

  always_ff @(posedge clock_in) begin
    if (rst_in || wr_high || tick) begin
      pre_cnt <= 6'h00;
    end else begin
      pre_cnt <= pre_cnt + 6'h01;
    end
  end

  // RULE10 RULE20 half period of divisor ticks
  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      refresh_cnt <= DIV_RESET;
      refresh_level <= 1'b1;
    end else if (wr_high) begin
      refresh_cnt <= {reg_wdata_in, div_low_pending};
      refresh_level <= 1'b1;
    end else if (tick) begin
      if (refresh_cnt <= 10'h001) begin
        refresh_cnt <= refresh_divisor;
        refresh_level <= !refresh_level;
      end else begin
        refresh_cnt <= refresh_cnt - 10'h001;
      end
    end
  end

  // RULE16 RULE17 pin low conditions per mode
  assign fault_low = otp_active || (latch_mode
    ? (|open_load_flags || |shorted_led_flags) : |faulted);

  always_comb begin
    if (fault_pin_select) begin
      next_pin_out = 1'b0;
      next_pin_oe = fault_low;
    end else begin
      next_pin_oe = 1'b1;
      // RULE9 zero divisor holds high
      next_pin_out = (refresh_divisor == DIV_OFF) ? 1'b1 : refresh_level;
    end
  end

  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      refresh_fault_pin_out <= 1'b1;
      refresh_fault_pin_oe_out <= 1'b1;
      channel_on_out <= '0;
    end else begin
      // RULE1 pin function select
      refresh_fault_pin_out <= next_pin_out;
      refresh_fault_pin_oe_out <= next_pin_oe;
      channel_on_out <= next_channel_on;
    end
  end

  // RULE5 staggered channel starts
  always_ff @(posedge clock_in) begin
    if (rst_in || !chip_en) begin
      channel_start_out <= '0;
      stag_active <= 1'b0;
      stag_idx <= 4'h0;
      stag_cnt <= '0;
    end else if (dim_period_start_in) begin
      channel_start_out <= phase_stagger_enable ? CHANNELS'(1) : '1;
      stag_active <= phase_stagger_enable;
      stag_idx <= 4'h1;
      stag_cnt <= '0;
    end else if (stag_active && stag_cnt == SCW'(STAGGER_CYCLES - 1)) begin
      channel_start_out <= CHANNELS'(1) << stag_idx;
      stag_idx <= stag_idx + 4'h1;
      stag_active <= (stag_idx != 4'hf);
      stag_cnt <= '0;
    end else begin
      channel_start_out <= '0;
      stag_cnt <= stag_active ? stag_cnt + 1'b1 : '0;
    end
  end

  a_pin_fault_mode: assert property ( // RULE1
    @(posedge clock_in) disable iff (rst_in)
    (fault_pin_select && fault_low) |=>
      (!refresh_fault_pin_out && refresh_fault_pin_oe_out)
  ) else $error("fault pin not pulled low in fault mode");
  a_pin_zero_div: assert property ( // RULE9
    @(posedge clock_in) disable iff (rst_in)
    (!fault_pin_select && refresh_divisor == DIV_OFF) [*2] |->
      (refresh_fault_pin_out && refresh_fault_pin_oe_out)
  ) else $error("refresh pin not high with zero divisor");
  a_low_held: assert property ( // RULE11
    @(posedge clock_in) disable iff (rst_in)
    (wr_low && !wr_high) |=> $stable(refresh_divisor)
  ) else $error("low divisor write changed the divisor");
  a_high_commit: assert property ( // RULE11
    @(posedge clock_in) disable iff (rst_in)
    wr_high |=> refresh_divisor == {$past(reg_wdata_in), $past(div_low_pending)}
  ) else $error("high divisor write did not commit");
  a_chip_off: assert property ( // RULE6
    @(posedge clock_in) disable iff (rst_in)
    !chip_en |=> channel_on_out == '0
  ) else $error("channel on while chip disabled");
  a_otp_flag: assert property ( // RULE7
    @(posedge clock_in) disable iff (rst_in)
    otp_active |=> overtemp_flag ##1 overtemp_flag
  ) else $error("overtemp flag not set");
  a_read_clears: assert property ( // RULE16
    @(posedge clock_in) disable iff (rst_in)
    (reg_rd_in && reg_addr_in == ADDR_OPEN_LOWER && open_set[7:0] == 8'h00)
      |=> open_load_flags[7:0] == 8'h00
  ) else $error("open flags not cleared by read");
  a_enable_write: assert property ( // RULE13
    @(posedge clock_in) disable iff (rst_in)
    (reg_wr_in && reg_addr_in == ADDR_CH_EN_LOWER) |=>
      channel_enable_bits[7:0] == $past(reg_wdata_in)
  ) else $error("channel enable write lost");
  a_stagger_gap: assert property ( // RULE5
    @(posedge clock_in) disable iff (rst_in)
    (channel_start_out == CHANNELS'(1) && stag_active && chip_en
      && !dim_period_start_in) |->
      ##[STAG_GAP:STAG_GAP] (channel_start_out[1] || !chip_en
      || $past(dim_period_start_in))
  ) else $error("second channel start not 40 us later");
  a_threshold_out: assert property ( // RULE3
    @(posedge clock_in) disable iff (rst_in)
    wr_ctrl |=> short_threshold_sel_out == $past(reg_wdata_in[5:4])
      && ramp_rate_sel_out == $past(reg_wdata_in[3:2])
  ) else $error("threshold or ramp select not updated");
endmodule

// ===== sim/ldcsr_host_model.sv
`timescale 1ns/1ps
module ldcsr_host_model
  import ldcsr_pkg::*;
(
  input wire logic clock_in,
  output logic [7:0] addr_out,
  output logic wr_out,
  output logic rd_out,
  output logic [7:0] wdata_out,
  input wire logic [7:0] rdata_in
);
  initial begin
    addr_out = 8'h00;
    wr_out = 1'b0;
    rd_out = 1'b0;
    wdata_out = 8'h00;
  end
  // one-cycle write strobe, bus inverted once released
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clock_in);
    addr_out <= a;
    wdata_out <= d;
    wr_out <= 1'b1;
    @(posedge clock_in);
    wr_out <= 1'b0;
    addr_out <= ~a;
    wdata_out <= ~d;
  endtask
  // read data taken one cycle after the strobe edge
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clock_in);
    addr_out <= a;
    rd_out <= 1'b1;
    @(posedge clock_in);
    rd_out <= 1'b0;
    addr_out <= ~a;
    @(posedge clock_in);
    d = rdata_in;
  endtask
endmodule

// ===== sim/ldcsr_regs_bench.sv
`timescale 1ns/1ps
module ldcsr_regs_bench;
  import ldcsr_pkg::*;
  localparam int QUAL = 20;
  localparam int PER = 1000;
  logic clock_in = 1'b0;
  logic rst_in = 1'b1;
  logic [1:0] fsel = 2'h1;
  logic dstart = 1'b0;
  logic [15:0] open_c = 16'h0000;
  logic [15:0] short_c = 16'h0000;
  logic otp = 1'b0;
  logic [7:0] addr, wdata, rdata, rv;
  logic wr, rd, pin, pin_oe;
  logic [15:0] ch_on, ch_start;
  logic [1:0] sth, ramp;
  logic [18:0] obs;
  logic [7:0] dflt [10] = '{8'h00, 8'h40, 8'h01, 8'h6a, 8'hff, 8'hff,
    8'h00, 8'h00, 8'h00, 8'h00};
  int err_total = 0;
  int num_checks = 0;
  int n, cnt;
  // pin line as seen through its pull-up
  assign obs = {ch_start[1:0], pin_oe ? pin : 1'b1, ch_on};
  always #50 clock_in = ~clock_in;

  ldcsr_host_model ldcsr_host_model_i (.clock_in(clock_in),
    .addr_out(addr), .wr_out(wr), .rd_out(rd), .wdata_out(wdata),
    .rdata_in(rdata));
  ldcsr_regs #(.QUAL_CYCLES(QUAL), .PERIOD_CYCLES(PER)) ldcsr_regs_i (
    .clock_in(clock_in), .rst_in(rst_in), .reg_addr_in(addr),
    .reg_wr_in(wr), .reg_rd_in(rd), .reg_wdata_in(wdata),
    .reg_rdata_out(rdata), .dimming_freq_sel_in(fsel),
    .dim_period_start_in(dstart), .open_detect_in(open_c),
    .short_detect_in(short_c), .overtemp_in(otp),
    .channel_on_out(ch_on), .channel_start_out(ch_start),
    .short_threshold_sel_out(sth), .ramp_rate_sel_out(ramp),
    .refresh_fault_pin_out(pin), .refresh_fault_pin_oe_out(pin_oe));

  task automatic finish_test();
    $display("checks %0d mismatches %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [15:0] e,
      input logic [15:0] g);
    num_checks++;
    if (g !== e) begin
      err_total++;
      $display("mismatch %s exp %h got %h", nm, e, g);
    end
  endtask
  task automatic rdchk(input logic [7:0] a, input logic [7:0] e);
    ldcsr_host_model_i.rd(a, rv);
    chk($sformatf("reg %h", a), {8'h00, e}, {8'h00, rv});
  endtask
  task automatic wsig(input int i, input logic v, input int lim);
    n = 0;
    num_checks++;
    while (obs[i] !== v) begin
      @(posedge clock_in);
      n++;
      if (n > lim) begin
        err_total++;
        $display("mismatch wait %0d exp %b got %b", i, v, obs[i]);
        finish_test();
      end
    end
  endtask
  task automatic hold_pin();
    cnt = 0;
    repeat (100) begin
      @(posedge clock_in);
      if (pin === 1'b1) cnt++;
    end
    chk("pin hold", 16'h0064, 16'(cnt));
  endtask
  task automatic half_period(input int lim);
    wsig(16, ~pin, lim);
    wsig(16, ~pin, lim);
  endtask
  task automatic pulse();
    @(posedge clock_in);
    dstart <= 1'b1;
    @(posedge clock_in);
    dstart <= 1'b0;
  endtask

  initial begin
    repeat (4) @(posedge clock_in);
    rst_in <= 1'b0;
    for (int a = 0; a < 10; a++) begin
      rdchk(8'(a), dflt[a]);
    end
    chk("pin", 16'h0003, {14'h0000, pin, pin_oe});
    chk("on", 16'h0000, ch_on);
    ldcsr_host_model_i.wr(8'h0a, 8'h55);
    rdchk(8'h0a, 8'h00);
    ldcsr_host_model_i.wr(8'h06, 8'hff);
    rdchk(8'h06, 8'h00);
    for (int k = 0; k < 4; k++) begin
      ldcsr_host_model_i.wr(8'h01, {2'h1, 2'(k), 2'(k), 2'h1});
      @(posedge clock_in);
      chk("sth", 16'(k), {14'h0000, sth});
      chk("ramp", 16'(k), {14'h0000, ramp});
    end
    rdchk(8'h01, 8'h7d);
    chk("on", 16'hffff, ch_on);
    ldcsr_host_model_i.wr(8'h05, 8'hfe);
    repeat (3) @(posedge clock_in);
    chk("on", 16'hfffe, ch_on);
    ldcsr_host_model_i.wr(8'h05, 8'hff);
    ldcsr_host_model_i.wr(8'h02, 8'h00);
    ldcsr_host_model_i.wr(8'h03, 8'h00);
    hold_pin();
    ldcsr_host_model_i.wr(8'h02, 8'h01);
    hold_pin();
    rdchk(8'h02, 8'h01);
    ldcsr_host_model_i.wr(8'h03, 8'h00);
    half_period(100);
    chk("half 250", 16'(TICK_250), 16'(n));
    fsel <= 2'h0;
    half_period(100);
    chk("half 220", 16'(TICK_220), 16'(n));
    fsel <= 2'h2;
    half_period(100);
    chk("half 280", 16'(TICK_280), 16'(n));
    fsel <= 2'h3;
    half_period(100);
    chk("half 330", 16'(TICK_330), 16'(n));
    fsel <= 2'h1;
    ldcsr_host_model_i.wr(8'h03, 8'h6a);
    repeat (3) @(posedge clock_in);
    half_period(17000);
    chk("half dflt", 16'(425 * TICK_250), 16'(n));
    ldcsr_host_model_i.wr(8'h01, 8'h43);
    pulse();
    wsig(17, 1'b1, 10);
    wsig(18, 1'b1, 500);
    chk("stagger", 16'(STAGGER_CYCLES), 16'(n));
    ldcsr_host_model_i.wr(8'h01, 8'h41);
    pulse();
    wsig(17, 1'b1, 10);
    chk("start", 16'hffff, ch_start);
    ldcsr_host_model_i.wr(8'h01, 8'hc1);
    open_c <= 16'h0004;
    wsig(2, 1'b0, QUAL + 20);
    chk("qual", 16'h0001, {15'h0000, n >= QUAL});
    wsig(16, 1'b0, 5);
    open_c <= 16'h0000;
    repeat (100) @(posedge clock_in);
    chk("latched", 16'h0000, {15'h0000, ch_on[2]});
    rdchk(8'h07, 8'h04);
    rdchk(8'h07, 8'h00);
    wsig(16, 1'b1, 5);
    ldcsr_host_model_i.wr(8'h01, 8'hc0);
    ldcsr_host_model_i.wr(8'h01, 8'hc1);
    wsig(2, 1'b1, 5);
    short_c <= 16'h8000;
    wsig(15, 1'b0, QUAL + 20);
    short_c <= 16'h0000;
    rdchk(8'h08, 8'h80);
    rdchk(8'h09, 8'h00);
    ldcsr_host_model_i.wr(8'h01, 8'h81);
    short_c <= 16'h0001;
    wsig(0, 1'b0, QUAL + 20);
    wsig(0, 1'b1, PER + 20);
    wsig(0, 1'b0, 400);
    chk("retry", 16'(RETRY_CYCLES), 16'(n));
    short_c <= 16'h0000;
    wsig(0, 1'b1, PER + 50);
    wsig(16, 1'b1, RETRY_CYCLES + 20);
    rdchk(8'h09, 8'h01);
    otp <= 1'b1;
    wsig(4, 1'b0, 20);
    wsig(16, 1'b0, 10);
    otp <= 1'b0;
    wsig(4, 1'b1, 20);
    rdchk(8'h02, 8'h05);
    rdchk(8'h02, 8'h05);
    finish_test();
  end
endmodule
